// File: dpr_defines.svh
// Offsets, field positions, reset values and sizes of the dual-port memory block
`ifndef DPR_DEFINES_SVH
`define DPR_DEFINES_SVH
`define DPR_OFF_CONFIG       8'h00
`define DPR_OFF_PRESET_A     8'h04
`define DPR_OFF_PRESET_B     8'h08
`define DPR_OFF_STARTUP_A    8'h0C
`define DPR_OFF_STARTUP_B    8'h10
`define DPR_OFF_EXTRA        8'h14
`define DPR_OFF_INDEX        8'h18
`define DPR_OFF_PRELOAD_DATA 8'h1C
`define DPR_OFF_PRELOAD_PAR  8'h20
`define DPR_OFF_STATUS       8'h24
`define DPR_CFG_RESET        32'h0000_0000
`define DPR_CFG_WIDTH_A      0
`define DPR_CFG_WIDTH_B      3
`define DPR_CFG_MODE_A       6
`define DPR_CFG_MODE_B       8
`define DPR_CFG_INV_A        10
`define DPR_CFG_INV_B        14
`define DPR_CFG_RUN          18
`define DPR_INV_CLOCK        0
`define DPR_INV_ACTIVATE     1
`define DPR_INV_WRITE        2
`define DPR_INV_PRESET       3
`define DPR_STATUS_COLLIDE   0
`define DPR_WCODE_MAX        3'h5
`define DPR_DATA_BITS        16384
`define DPR_PAR_BITS         2048
`define DPR_MAX_DATA         32
`define DPR_MAX_PAR          4
`define DPR_BUNDLE_W         54
`define DPR_BND_CLOCK        53
`define DPR_BND_ACTIVATE     52
`define DPR_BND_WRITE        51
`define DPR_BND_PRESET       50
`define DPR_BND_ADDR         36
`define DPR_BND_DATA         4
`define DPR_BND_PAR          0
`endif

// File: dpr_pkg.sv
// Types shared by the dual-port memory block
`default_nettype none
package dpr_pkg;
  typedef enum logic [1:0] {DPR_WRITE_THROUGH, DPR_READ_FIRST, DPR_HOLD} dpr_mode_type;

  typedef struct packed {
    logic        prev;
    logic        fire;
    logic        en;
    logic        we;
    logic        pre;
    logic [13:0] addr;
    logic [31:0] din;
    logic [3:0]  pin;
  } dpr_front_state_type;

  typedef struct packed {
    logic [31:0]       cfg;
    logic [1:0][31:0]  preset_data;
    logic [1:0][31:0]  startup_data;
    logic [15:0]       extra;
    logic [8:0]        index;
    logic              collide;
    logic [1:0][31:0]  latch_d;
    logic [1:0][3:0]   latch_p;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
  } dpr_top_state_type;
endpackage
`default_nettype wire

// File: dpr_sync2.sv
// Two flip-flop synchroniser for a bundle of port pins
`default_nettype none
module dpr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Bundle
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } dpr_sync_state_type;

  dpr_sync_state_type s_r;
  dpr_sync_state_type s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = din;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.sync;
endmodule
`default_nettype wire

// File: dpr_port_front.sv
// Polarity selection and active-edge detection for one memory port
`include "dpr_defines.svh"
`default_nettype none
module dpr_port_front (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Synchronised pins and sense selection
  input  wire logic [53:0] bundle,
  input  wire logic [3:0]  invert,
  // Sampled port request
  output logic             fire,
  output logic             en,
  output logic             we,
  output logic             pre,
  output logic [13:0]      addr,
  output logic [31:0]      din,
  output logic [3:0]       pin
);
  dpr_pkg::dpr_front_state_type s_r;
  dpr_pkg::dpr_front_state_type s_nxt;
  logic                         clk_eff;

  always_comb begin
    clk_eff    = bundle[`DPR_BND_CLOCK] ^ invert[`DPR_INV_CLOCK];
    s_nxt      = s_r;
    s_nxt.prev = clk_eff;
    s_nxt.fire = clk_eff & ~s_r.prev;
    s_nxt.en   = bundle[`DPR_BND_ACTIVATE] ^ invert[`DPR_INV_ACTIVATE];
    s_nxt.we   = bundle[`DPR_BND_WRITE] ^ invert[`DPR_INV_WRITE];
    s_nxt.pre  = bundle[`DPR_BND_PRESET] ^ invert[`DPR_INV_PRESET];
    s_nxt.addr = bundle[`DPR_BND_ADDR +: 14];
    s_nxt.din  = bundle[`DPR_BND_DATA +: 32];
    s_nxt.pin  = bundle[`DPR_BND_PAR +: 4];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fire = s_r.fire;
  assign en   = s_r.en;
  assign we   = s_r.we;
  assign pre  = s_r.pre;
  assign addr = s_r.addr;
  assign din  = s_r.din;
  assign pin  = s_r.pin;
endmodule
`default_nettype wire

// File: dpr_dual_port_ram.sv
// Dual-port memory with per-port width, write policy, presets and APB setup
//
// Decided for this implementation: the address map and the APB slave port.
`include "dpr_defines.svh"
`default_nettype none
module dpr_dual_port_ram (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic      [31:0] PRDATA,
  output logic             PSLVERR,
  // Port A
  input  wire logic        PORT_A_TIMEBASE,
  input  wire logic        PORT_A_ACTIVATE,
  input  wire logic        PORT_A_WRITE_STROBE,
  input  wire logic        PORT_A_OUTPUT_PRESET,
  input  wire logic [13:0] PORT_A_LOCATION_SELECT,
  input  wire logic [31:0] PORT_A_STORE_BUS,
  input  wire logic [3:0]  PORT_A_EXTRA_BITS_IN,
  output logic      [31:0] PORT_A_FETCH_BUS,
  output logic      [3:0]  PORT_A_EXTRA_BITS_OUT,
  // Port B
  input  wire logic        PORT_B_TIMEBASE,
  input  wire logic        PORT_B_ACTIVATE,
  input  wire logic        PORT_B_WRITE_STROBE,
  input  wire logic        PORT_B_OUTPUT_PRESET,
  input  wire logic [13:0] PORT_B_LOCATION_SELECT,
  input  wire logic [31:0] PORT_B_STORE_BUS,
  input  wire logic [3:0]  PORT_B_EXTRA_BITS_IN,
  output logic      [31:0] PORT_B_FETCH_BUS,
  output logic      [3:0]  PORT_B_EXTRA_BITS_OUT
);
  // Width code 0..5 stands for 36, 18, 9, 4, 2, 1 bits
  function automatic logic [2:0] wnorm(input logic [2:0] c);
    return (c > `DPR_WCODE_MAX) ? `DPR_WCODE_MAX : c;
  endfunction

  function automatic logic [5:0] dbits(input logic [2:0] c);
    return 6'(6'h20 >> c);
  endfunction

  function automatic logic [2:0] pbits(input logic [2:0] c);
    return (c <= 3'h2) ? 3'(3'h4 >> c) : 3'h0;
  endfunction

  // Shift drops address bits above the port's address width
  function automatic logic [13:0] dbase_f(input logic [13:0] a, input logic [2:0] c);
    return 14'(a << (3'h5 - c));
  endfunction

  function automatic logic [10:0] pbase_f(input logic [13:0] a, input logic [2:0] c);
    return (c <= 3'h2) ? 11'(a << (3'h2 - c)) : 11'h000;
  endfunction

  function automatic logic [31:0] dmask(input logic [2:0] c);
    return 32'((33'h1 << dbits(c)) - 33'h1);
  endfunction

  function automatic logic [3:0] pmask(input logic [2:0] c);
    return 4'((5'h01 << pbits(c)) - 5'h01);
  endfunction

  logic                      data_mem [0:`DPR_DATA_BITS-1];
  logic                      par_mem  [0:`DPR_PAR_BITS-1];

  dpr_pkg::dpr_top_state_type s_r;
  dpr_pkg::dpr_top_state_type s_nxt;

  logic [1:0][53:0]          raw;
  logic [1:0][53:0]          synced;
  logic [1:0][3:0]           inv;
  logic [1:0]                fire;
  logic [1:0]                en;
  logic [1:0]                we;
  logic [1:0]                pre;
  logic [1:0][13:0]          addr;
  logic [1:0][31:0]          din;
  logic [1:0][3:0]           pin;

  logic [1:0][2:0]           code;
  dpr_pkg::dpr_mode_type     mode [2];
  logic [1:0][13:0]          dbase;
  logic [1:0][10:0]          pbase;
  logic [1:0][31:0]          rd_d;
  logic [1:0][3:0]           rd_p;
  logic [1:0][31:0]          wr_d;
  logic [1:0][3:0]           wr_p;
  logic [1:0][31:0]          pre_d;
  logic [1:0][3:0]           pre_p;
  logic [1:0][31:0]          st_d;
  logic [1:0][3:0]           st_p;
  logic [1:0]                act;
  logic [1:0]                wr_go;
  logic [31:0]               word_rd;
  logic [3:0]                word_par;
  logic                      run;
  logic                      run_start;
  logic                      setup;
  logic                      wr_cyc;
  logic                      load_ok;
  logic                      clash;
  logic                      clr;

  assign raw[0] = {PORT_A_TIMEBASE, PORT_A_ACTIVATE, PORT_A_WRITE_STROBE,
                   PORT_A_OUTPUT_PRESET, PORT_A_LOCATION_SELECT, PORT_A_STORE_BUS,
                   PORT_A_EXTRA_BITS_IN};
  assign raw[1] = {PORT_B_TIMEBASE, PORT_B_ACTIVATE, PORT_B_WRITE_STROBE,
                   PORT_B_OUTPUT_PRESET, PORT_B_LOCATION_SELECT, PORT_B_STORE_BUS,
                   PORT_B_EXTRA_BITS_IN};
  assign inv[0] = s_r.cfg[`DPR_CFG_INV_A +: 4];
  assign inv[1] = s_r.cfg[`DPR_CFG_INV_B +: 4];

  for (genvar g = 0; g < 2; g++) begin : g_port
    dpr_sync2 #(.W(`DPR_BUNDLE_W)) u_sync (
      .clock (CLOCK),
      .rst   (RST),
      .din   (raw[g]),
      .dout  (synced[g])
    );
    dpr_port_front u_front (
      .clock  (CLOCK),
      .rst    (RST),
      .bundle (synced[g]),
      .invert (inv[g]),
      .fire   (fire[g]),
      .en     (en[g]),
      .we     (we[g]),
      .pre    (pre[g]),
      .addr   (addr[g]),
      .din    (din[g]),
      .pin    (pin[g])
    );
  end

  assign run = s_r.cfg[`DPR_CFG_RUN];

  // Per-port decode of width, location and masked values
  always_comb begin
    code[0] = wnorm(s_r.cfg[`DPR_CFG_WIDTH_A +: 3]);
    code[1] = wnorm(s_r.cfg[`DPR_CFG_WIDTH_B +: 3]);
    mode[0] = dpr_pkg::dpr_mode_type'(s_r.cfg[`DPR_CFG_MODE_A +: 2]);
    mode[1] = dpr_pkg::dpr_mode_type'(s_r.cfg[`DPR_CFG_MODE_B +: 2]);
    for (int p = 0; p < 2; p++) begin
      dbase[p] = dbase_f(addr[p], code[p]);
      pbase[p] = pbase_f(addr[p], code[p]);
      wr_d[p]  = din[p] & dmask(code[p]);
      wr_p[p]  = pin[p] & pmask(code[p]);
      pre_d[p] = s_r.preset_data[p] & dmask(code[p]);
      pre_p[p] = s_r.extra[4*p +: 4] & pmask(code[p]);
      st_d[p]  = s_r.startup_data[p] & dmask(code[p]);
      st_p[p]  = s_r.extra[8+4*p +: 4] & pmask(code[p]);
      act[p]   = run & fire[p] & en[p];
      wr_go[p] = act[p] & we[p];
      // narrow words packed inside the shared store
      for (int i = 0; i < `DPR_MAX_DATA; i++) begin
        rd_d[p][i] = (i < int'(dbits(code[p]))) ? data_mem[14'(dbase[p] + 14'(i))] : 1'b0;
      end
      for (int i = 0; i < `DPR_MAX_PAR; i++) begin
        rd_p[p][i] = (i < int'(pbits(code[p]))) ? par_mem[11'(pbase[p] + 11'(i))] : 1'b0;
      end
    end
    for (int i = 0; i < `DPR_MAX_DATA; i++) begin
      word_rd[i] = data_mem[{s_r.index, 5'(i)}];
    end
    for (int i = 0; i < `DPR_MAX_PAR; i++) begin
      word_par[i] = par_mem[{s_r.index, 2'(i)}];
    end
  end

  // Same-location clash with at least one writer
  // clash detection
  assign clash = act[0] & act[1] & (we[0] | we[1]) &
                 ({1'b0, dbase[0]} < 15'({1'b0, dbase[1]} + 15'(dbits(code[1])))) &
                 ({1'b0, dbase[1]} < 15'({1'b0, dbase[0]} + 15'(dbits(code[0]))));

  assign setup   = PSEL & ~PENABLE;
  assign wr_cyc  = PSEL & PENABLE & s_r.pready & PWRITE & ~s_r.pslverr;
  assign load_ok = wr_cyc & ~run;

  always_comb begin
    s_nxt     = s_r;
    clr       = 1'b0;
    run_start = 1'b0;
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.pslverr = 1'b0;
      case (PADDR)
        `DPR_OFF_CONFIG:       s_nxt.prdata = s_r.cfg;
        `DPR_OFF_PRESET_A:     s_nxt.prdata = s_r.preset_data[0];
        `DPR_OFF_PRESET_B:     s_nxt.prdata = s_r.preset_data[1];
        `DPR_OFF_STARTUP_A:    s_nxt.prdata = s_r.startup_data[0];
        `DPR_OFF_STARTUP_B:    s_nxt.prdata = s_r.startup_data[1];
        `DPR_OFF_EXTRA:        s_nxt.prdata = {16'h0000, s_r.extra};
        `DPR_OFF_INDEX:        s_nxt.prdata = {23'h000000, s_r.index};
        `DPR_OFF_PRELOAD_DATA: begin
          s_nxt.prdata  = word_rd;
          s_nxt.pslverr = PWRITE & run;
        end
        `DPR_OFF_PRELOAD_PAR: begin
          s_nxt.prdata  = {28'h0000000, word_par};
          s_nxt.pslverr = PWRITE & run;
        end
        `DPR_OFF_STATUS:       s_nxt.prdata = {30'h00000000, run, s_r.collide};
        default: begin
          s_nxt.prdata  = 32'h0000_0000;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_cyc) begin
      case (PADDR)
        `DPR_OFF_CONFIG: begin
          s_nxt.cfg = PWDATA;
          run_start = PWDATA[`DPR_CFG_RUN] & ~run;
        end
        `DPR_OFF_PRESET_A:  s_nxt.preset_data[0]  = PWDATA;
        `DPR_OFF_PRESET_B:  s_nxt.preset_data[1]  = PWDATA;
        `DPR_OFF_STARTUP_A: s_nxt.startup_data[0] = PWDATA;
        `DPR_OFF_STARTUP_B: s_nxt.startup_data[1] = PWDATA;
        `DPR_OFF_EXTRA:     s_nxt.extra = PWDATA[15:0];
        `DPR_OFF_INDEX:     s_nxt.index = PWDATA[8:0];
        `DPR_OFF_STATUS:    clr = PWDATA[`DPR_STATUS_COLLIDE];
        default:            clr = 1'b0;
      endcase
    end
    // A clash in the clearing cycle stays flagged
    s_nxt.collide = clash | (s_r.collide & ~clr);
    for (int p = 0; p < 2; p++) begin
      if (run_start) begin
        s_nxt.latch_d[p] = st_d[p];
        s_nxt.latch_p[p] = st_p[p];
      end else if (act[p]) begin
        if (pre[p]) begin
          s_nxt.latch_d[p] = pre_d[p];
          s_nxt.latch_p[p] = pre_p[p];
        end else if (!we[p]) begin
          s_nxt.latch_d[p] = rd_d[p];
          s_nxt.latch_p[p] = rd_p[p];
        end else begin
          case (mode[p])
            dpr_pkg::DPR_WRITE_THROUGH: begin
              s_nxt.latch_d[p] = wr_d[p];
              s_nxt.latch_p[p] = wr_p[p];
            end
            dpr_pkg::DPR_READ_FIRST: begin
              s_nxt.latch_d[p] = rd_d[p];
              s_nxt.latch_p[p] = rd_p[p];
            end
            default: begin
              s_nxt.latch_d[p] = s_r.latch_d[p];
              s_nxt.latch_p[p] = s_r.latch_p[p];
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_r     <= '0;
      s_r.cfg <= `DPR_CFG_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Store updates; port B lands last when both write one bit
  always_ff @(posedge CLOCK) begin
    for (int p = 0; p < 2; p++) begin
      // write data and extra bits alike
      if (wr_go[p]) begin
        for (int i = 0; i < `DPR_MAX_DATA; i++) begin
          if (i < int'(dbits(code[p]))) begin
            data_mem[14'(dbase[p] + 14'(i))] <= din[p][i];
          end
        end
        for (int i = 0; i < `DPR_MAX_PAR; i++) begin
          if (i < int'(pbits(code[p]))) begin
            par_mem[11'(pbase[p] + 11'(i))] <= pin[p][i];
          end
        end
      end
    end
    if (load_ok && PADDR == `DPR_OFF_PRELOAD_DATA) begin
      for (int i = 0; i < `DPR_MAX_DATA; i++) begin
        data_mem[{s_r.index, 5'(i)}] <= PWDATA[i];
      end
    end
    if (load_ok && PADDR == `DPR_OFF_PRELOAD_PAR) begin
      for (int i = 0; i < `DPR_MAX_PAR; i++) begin
        par_mem[{s_r.index, 2'(i)}] <= PWDATA[i];
      end
    end
  end

  assign PREADY                = s_r.pready;
  assign PRDATA                = s_r.prdata;
  assign PSLVERR               = s_r.pslverr;
  assign PORT_A_FETCH_BUS      = s_r.latch_d[0];
  assign PORT_A_EXTRA_BITS_OUT = s_r.latch_p[0];
  assign PORT_B_FETCH_BUS      = s_r.latch_d[1];
  assign PORT_B_EXTRA_BITS_OUT = s_r.latch_p[1];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  property p_disabled;
    run && fire[0] && !en[0] |=> $stable(s_r.latch_d[0]) && $stable(s_r.latch_p[0]);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled port changed latch");

  property p_preset;
    act[0] && pre[0] |=> s_r.latch_d[0] == $past(pre_d[0]) && s_r.latch_p[0] == $past(pre_p[0]);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");

  property p_preset_store;
    wr_go[0] && pre[0] && !wr_go[1] ##1 addr[0] == $past(addr[0]) && $stable(code[0])
      |-> rd_d[0] == $past(wr_d[0]);
  endproperty
  a_preset_store: assert property (p_preset_store) else $error("preset write lost");

  property p_store;
    wr_go[0] && !wr_go[1] ##1 addr[0] == $past(addr[0]) && $stable(code[0])
      |-> rd_d[0] == $past(wr_d[0]) && rd_p[0] == $past(wr_p[0]);
  endproperty
  a_store: assert property (p_store) else $error("write not stored");

  property p_read;
    act[0] && !we[0] && !pre[0] |=> s_r.latch_d[0] == $past(rd_d[0]);
  endproperty
  a_read: assert property (p_read) else $error("read not loaded");

  property p_through;
    wr_go[1] && !pre[1] && mode[1] == dpr_pkg::DPR_WRITE_THROUGH
      |=> s_r.latch_d[1] == $past(wr_d[1]);
  endproperty
  a_through: assert property (p_through) else $error("write-through wrong");

  property p_before;
    wr_go[0] && !pre[0] && mode[0] == dpr_pkg::DPR_READ_FIRST
      |=> s_r.latch_d[0] == $past(rd_d[0]) && s_r.latch_p[0] == $past(rd_p[0]);
  endproperty
  a_before: assert property (p_before) else $error("read-first wrong");

  property p_hold;
    wr_go[0] && !pre[0] && mode[0] == dpr_pkg::DPR_HOLD |=> $stable(s_r.latch_d[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("hold mode changed latch");

  property p_edge;
    !act[1] && !run_start |=> $stable(s_r.latch_d[1]) [*1] ##0 $stable(s_r.latch_p[1]);
  endproperty
  a_edge: assert property (p_edge) else $error("latch moved without edge");

  property p_startup;
    run_start |=> s_r.latch_d[1] == $past(st_d[1]) ##1 run;
  endproperty
  a_startup: assert property (p_startup) else $error("startup value not loaded");
endmodule
`default_nettype wire

// File: dpr_port_user.sv
// Behavioural user logic that drives one memory port
`default_nettype none
module dpr_port_user (
  // System clock that paces the pins
  input  wire logic        clock,
  // Port pins
  output logic             tbase,
  output logic             act,
  output logic             wr,
  output logic             pre,
  output logic      [13:0] adr,
  output logic      [31:0] din,
  output logic      [3:0]  pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tbase = 1'b0;
    act   = 1'b0;
    wr    = 1'b0;
    pre   = 1'b0;
    adr   = 14'h0000;
    din   = 32'h0000_0000;
    pin   = 4'h0;
  end

  // One port cycle: pins settle, a single port edge, then release
  task automatic op(input logic e, w, p, input logic [13:0] a, input logic [31:0] d,
                    input logic [3:0] x);
    @(posedge clock);
    act <= e;
    wr  <= w;
    pre <= p;
    adr <= a;
    din <= d;
    pin <= x;
    repeat (4) @(posedge clock);
    tbase <= 1'b1;
    repeat (4) @(posedge clock);
    tbase <= 1'b0;
    repeat (4) @(posedge clock);
    // Hold time over: lines stop showing the request, port clock stands still
    act <= ~e;
    wr  <= ~w;
    pre <= ~p;
    adr <= ~a;
    din <= ~d;
    pin <= ~x;
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the dual-port memory block
`include "dpr_defines.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, a_dout, b_dout, a_din, b_din;
  logic [3:0]  a_pout, b_pout, a_pin, b_pin;
  logic        a_clk, a_en, a_we, a_pre, b_clk, b_en, b_we, b_pre;
  logic [13:0] a_adr, b_adr;
  int          num_errors = 0;
  int          checks_done = 0;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  dpr_dual_port_ram uut (
    .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .PORT_A_TIMEBASE(a_clk), .PORT_A_ACTIVATE(a_en), .PORT_A_WRITE_STROBE(a_we),
    .PORT_A_OUTPUT_PRESET(a_pre), .PORT_A_LOCATION_SELECT(a_adr), .PORT_A_STORE_BUS(a_din),
    .PORT_A_EXTRA_BITS_IN(a_pin), .PORT_A_FETCH_BUS(a_dout), .PORT_A_EXTRA_BITS_OUT(a_pout),
    .PORT_B_TIMEBASE(b_clk), .PORT_B_ACTIVATE(b_en), .PORT_B_WRITE_STROBE(b_we),
    .PORT_B_OUTPUT_PRESET(b_pre), .PORT_B_LOCATION_SELECT(b_adr), .PORT_B_STORE_BUS(b_din),
    .PORT_B_EXTRA_BITS_IN(b_pin), .PORT_B_FETCH_BUS(b_dout), .PORT_B_EXTRA_BITS_OUT(b_pout));
  dpr_port_user ua (.clock(clock), .tbase(a_clk), .act(a_en), .wr(a_we), .pre(a_pre),
    .adr(a_adr), .din(a_din), .pin(a_pin));
  dpr_port_user ub (.clock(clock), .tbase(b_clk), .act(b_en), .wr(b_we), .pre(b_pre),
    .adr(b_adr), .din(b_din), .pin(b_pin));

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, then its response code and read data are compared
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    chk({3'h0, pslverr, w ? d : prdata}, {3'h0, e, d});
  endtask

  task automatic summarize;
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    summarize();
  end

  initial begin
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    xfer(1'b0, `DPR_OFF_CONFIG, 32'h0000_0000, 1'b0);
    xfer(1'b0, 8'h28, 32'h0000_0000, 1'b1);
    xfer(1'b1, `DPR_OFF_INDEX, 32'h0000_0005, 1'b0);
    xfer(1'b1, `DPR_OFF_PRELOAD_DATA, 32'hA5C3_1E7F, 1'b0);
    xfer(1'b1, `DPR_OFF_PRELOAD_PAR, 32'h0000_0009, 1'b0);
    xfer(1'b0, `DPR_OFF_PRELOAD_DATA, 32'hA5C3_1E7F, 1'b0);
    xfer(1'b1, `DPR_OFF_STARTUP_A, 32'h1234_5678, 1'b0);
    xfer(1'b1, `DPR_OFF_PRESET_A, 32'hCAFE_0001, 1'b0);
    xfer(1'b1, `DPR_OFF_EXTRA, 32'h0000_0B06, 1'b0);
    xfer(1'b1, `DPR_OFF_CONFIG, 32'h0004_0010, 1'b0);
    // Startup value lands at the edge that ends the write, so look one edge later
    @(posedge clock);
    chk({a_pout, a_dout}, 36'hB_1234_5678);
    xfer(1'b0, `DPR_OFF_STATUS, 32'h0000_0002, 1'b0);
    xfer(1'b1, `DPR_OFF_PRELOAD_DATA, 32'h0000_0000, 1'b1);
    // one port at a time, so no clash on a shared location
    ua.op(1'b1, 1'b0, 1'b0, 14'd5, 32'h0000_0000, 4'h0);
    chk({a_pout, a_dout}, 36'h9_A5C3_1E7F);
    ub.op(1'b1, 1'b0, 1'b0, 14'd23, 32'h0000_0000, 4'h0);
    chk({b_pout, b_dout}, 36'h1_0000_00A5);
    ub.op(1'b1, 1'b1, 1'b0, 14'd21, 32'h0000_0077, 4'h0);
    chk({b_pout, b_dout}, 36'h0_0000_0077);
    ua.op(1'b1, 1'b0, 1'b0, 14'd5, 32'h0000_0000, 4'h0);
    chk({a_pout, a_dout}, 36'h9_A5C3_777F);
    ua.op(1'b1, 1'b1, 1'b1, 14'd6, 32'h0F0F_F0F0, 4'h3);
    chk({a_pout, a_dout}, 36'h6_CAFE_0001);
    ua.op(1'b0, 1'b1, 1'b0, 14'd6, 32'h0000_0000, 4'h0);
    chk({a_pout, a_dout}, 36'h6_CAFE_0001);
    ua.op(1'b1, 1'b0, 1'b0, 14'd6, 32'h0000_0000, 4'h0);
    chk({a_pout, a_dout}, 36'h3_0F0F_F0F0);
    xfer(1'b1, `DPR_OFF_CONFIG, 32'h0004_0050, 1'b0);
    ua.op(1'b1, 1'b1, 1'b0, 14'd6, 32'h1111_2222, 4'h1);
    chk({a_pout, a_dout}, 36'h3_0F0F_F0F0);
    xfer(1'b1, `DPR_OFF_CONFIG, 32'h0004_0090, 1'b0);
    ua.op(1'b1, 1'b1, 1'b0, 14'd6, 32'h3333_4444, 4'h5);
    chk({a_pout, a_dout}, 36'h3_0F0F_F0F0);
    ua.op(1'b1, 1'b0, 1'b0, 14'd6, 32'h0000_0000, 4'h0);
    chk({a_pout, a_dout}, 36'h5_3333_4444);
    xfer(1'b1, `DPR_OFF_CONFIG, 32'h0004_0800, 1'b0);
    ua.op(1'b0, 1'b1, 1'b0, 14'd5, 32'h0BAD_F00D, 4'h2);
    chk({a_pout, a_dout}, 36'h2_0BAD_F00D);
    // both ports on one word: port A's output and the flag are checked, never port B's data
    fork
      ua.op(1'b0, 1'b1, 1'b0, 14'd7, 32'h5A5A_A5A5, 4'h1);
      ub.op(1'b1, 1'b0, 1'b0, 14'd7, 32'h0000_0000, 4'h0);
    join
    chk({a_pout, a_dout}, 36'h1_5A5A_A5A5);
    xfer(1'b0, `DPR_OFF_STATUS, 32'h0000_0003, 1'b0);
    xfer(1'b1, `DPR_OFF_STATUS, 32'h0000_0001, 1'b0);
    xfer(1'b0, `DPR_OFF_STATUS, 32'h0000_0002, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
